// File: logic/bsd_pkg.sv
// Constants for the power-up strap decoder.
// Assumes a 50 MHz reference clock and a converter that returns a 3-bit level code.
// What this block does
// - Sample the strap pin once at power-up, digitise into one of eight levels.
// - After capture the decoded value stays fixed whatever the pin does later.
// - Level selects bus mode; address only in fixed mode, strap_level_input only in ARP mode.
// - Four highest levels select ARP mode with strap_level_input codes 111, 110, 101, 100.
// - Four lowest levels select fixed mode with addresses 0x53, 0x52, 0x51, 0x50.
// - In ARP mode strap_level_input bits sit in low identifier field beside 16-bit random number.
// - In fixed mode the strap address stays; an assign-address command cannot replace it.
package bsd_pkg;
	localparam int LEVEL_W = 3;
	localparam int ADDR_W = 7;
	localparam int LOC_W = 3;
	localparam int RAND_W = 16;
	localparam int VSID_W = 32;
	localparam logic [ADDR_W-1:0] FIXED_ADDR_BASE = 7'h50;
	localparam logic [LEVEL_W-1:0] ARP_LEVEL_MIN = 3'h4;
	localparam logic [LOC_W-1:0] LOC_RESET = 3'h0;
	localparam logic [ADDR_W-1:0] ADDR_RESET = 7'h00;
	localparam logic [RAND_W-1:0] LFSR_SEED = 16'hace1;
	localparam logic [RAND_W-1:0] LFSR_TAPS = 16'hb400;
	// Settling time before the converter is started, in ns.
	localparam int SETTLE_NS = 2000;
	localparam int CLK_PERIOD_NS = 20;
	localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 8;
	typedef enum logic [3:0] {
		BSD_SETTLE = 4'h1,
		BSD_START = 4'h2,
		BSD_WAIT = 4'h4,
		BSD_DONE = 4'h8
	} bsd_state_e;
endpackage

// File: logic/bsd_sync.sv
// Two-flop synchroniser for a single level.
// Assumes the input is asynchronous to clk_i.
`timescale 1ns/1ps
module bsd_sync (
	input wire logic clk_i, // Clock.
	input wire logic rst_i, // Asynchronous reset, active high.
	input wire logic en_i, // Clock enable.
	input wire logic d_i, // Asynchronous input.
	output logic q_o // Synchronised output.
);
	logic meta_q;
	// The first stage feeds only the second stage.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			meta_q <= 1'b0;
			q_o <= 1'b0;
		end else if (en_i) begin
			meta_q <= d_i;
			q_o <= meta_q;
		end
	end
endmodule

// File: logic/bsd_strap_decoder.sv
// Power-up strap decoder: starts one conversion, latches the level, decodes bus mode.
// Assumes rst_i is the power-on reset and the converter holds its code while done is high.
`timescale 1ns/1ps
module bsd_strap_decoder (
	input wire logic ref_clk_i, // 50 MHz clock.
	input wire logic rst_i, // Power-on reset, asynchronous, active high.
	input wire logic clk_en_i, // Clock enable; all state frozen while low.
	input wire logic [bsd_pkg::LEVEL_W-1:0] strap_level_input_i, // Converter level code.
	input wire logic conv_done_i, // Converter done, from outside the clock domain.
	input wire logic assign_addr_i, // Assign-address command pulse from bus logic.
	input wire logic [bsd_pkg::ADDR_W-1:0] assign_addr_val_i, // Address carried by it.
	output logic conv_start_o, // One-cycle start pulse to the converter.
	output logic strap_valid_o, // Decoded outputs are valid.
	output logic fixed_discoverable_mode_o, // 1 fixed mode, 0 ARP mode.
	output logic [bsd_pkg::ADDR_W-1:0] slave_addr_o, // Active slave address.
	output logic [bsd_pkg::LOC_W-1:0] strap_level_input_id_bits_o, // Strap_level_input bits for ARP mode.
	output logic [bsd_pkg::VSID_W-1:0] vendor_spec_id_o // Low identifier field.
);
	bsd_pkg::bsd_state_e state_q;
	logic [bsd_pkg::CNT_W-1:0] cnt_q;
	logic done_s;
	logic [bsd_pkg::LEVEL_W-1:0] level_q;
	logic [bsd_pkg::RAND_W-1:0] lfsr_q;
	logic level_ok;

	// The done line comes from the analog side, so it is synchronised first.
	bsd_sync u_done_sync (
		.clk_i(ref_clk_i),
		.rst_i(rst_i),
		.en_i(clk_en_i),
		.d_i(conv_done_i),
		.q_o(done_s)
	);

	// Sequencer: settle, one start pulse, wait for done, then stay done for good.
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_q <= bsd_pkg::BSD_SETTLE;
			cnt_q <= '0;
			conv_start_o <= 1'b0;
		end else if (clk_en_i) begin
			conv_start_o <= 1'b0;
			case (state_q)
				bsd_pkg::BSD_SETTLE: begin
					if (cnt_q == bsd_pkg::CNT_W'(bsd_pkg::SETTLE_CYC - 1)) begin
						state_q <= bsd_pkg::BSD_START;
					end else begin
						cnt_q <= cnt_q + 8'h01;
					end
				end
				bsd_pkg::BSD_START: begin
					conv_start_o <= 1'b1;
					state_q <= bsd_pkg::BSD_WAIT;
				end
				bsd_pkg::BSD_WAIT: begin
					if (done_s) begin
						state_q <= bsd_pkg::BSD_DONE;
					end
				end
				bsd_pkg::BSD_DONE: begin
					state_q <= bsd_pkg::BSD_DONE;
				end
				default: begin
					state_q <= bsd_pkg::BSD_SETTLE;
				end
			endcase
		end
	end

	// Capture happens on the one enabled edge that finds the converter done while waiting.
	// A late or repeated done pulse cannot reopen it, since the state has moved on by then.
	assign level_ok = (state_q == bsd_pkg::BSD_WAIT) && done_s;

	// The level is caught once; nothing reopens this latch short of power-on reset.
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			level_q <= '0;
		end else if (clk_en_i && level_ok) begin
			level_q <= strap_level_input_i;
		end
	end

	// Generator steps on each enabled cycle until capture; its value is frozen into the identifier at capture.
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			lfsr_q <= bsd_pkg::LFSR_SEED;
		end else if (clk_en_i && state_q != bsd_pkg::BSD_DONE) begin
			lfsr_q <= lfsr_q[0] ? ((lfsr_q >> 1) ^ bsd_pkg::LFSR_TAPS) : (lfsr_q >> 1);
		end
	end

	// Decode is registered in the capture cycle, so outputs go valid together.
	// The assign-address input is deliberately not used: fixed mode ignores it.
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			strap_valid_o <= 1'b0;
			fixed_discoverable_mode_o <= 1'b0;
			slave_addr_o <= bsd_pkg::ADDR_RESET;
			strap_level_input_id_bits_o <= bsd_pkg::LOC_RESET;
			vendor_spec_id_o <= '0;
		end else if (clk_en_i && level_ok) begin
			strap_valid_o <= 1'b1;
			if (strap_level_input_i >= bsd_pkg::ARP_LEVEL_MIN) begin
				fixed_discoverable_mode_o <= 1'b0;
				slave_addr_o <= bsd_pkg::ADDR_RESET;
				strap_level_input_id_bits_o <= strap_level_input_i;
				vendor_spec_id_o <= {13'h0000, strap_level_input_i, lfsr_q};
			end else begin
				fixed_discoverable_mode_o <= 1'b1;
				slave_addr_o <= bsd_pkg::FIXED_ADDR_BASE | {5'h00, strap_level_input_i[1:0]};
				strap_level_input_id_bits_o <= bsd_pkg::LOC_RESET;
				vendor_spec_id_o <= '0;
			end
		end
	end

	// The assign-address pair is folded away here so that no input dangles.
	// Fixed mode must never act on it, and nothing downstream reads this net.
	logic unused_s;
	assign unused_s = assign_addr_i ^ (^assign_addr_val_i);

	// Outputs stay invalid until the capture.
	valid_wait_a: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		(state_q != bsd_pkg::BSD_DONE) |-> !strap_valid_o
	) else $error("valid raised before capture");

	// Once valid, every decoded output keeps its value, the random field included.
	outputs_frozen_a: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		strap_valid_o |=> (strap_valid_o && $stable(slave_addr_o)
			&& $stable(fixed_discoverable_mode_o) && $stable(strap_level_input_id_bits_o)
			&& $stable(vendor_spec_id_o))
	) else $error("decoded strap changed after capture");

	// The latched level must agree with what the outputs show.
	// A stray reload of either side would split them apart and be caught here.
	level_match_a: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		strap_valid_o |-> (fixed_discoverable_mode_o
			? (!level_q[2] && slave_addr_o[1:0] == level_q[1:0])
			: (strap_level_input_id_bits_o == level_q))
	) else $error("latched level disagrees with outputs");

	// Capture raises valid on the next edge.
	capture_valid_a: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		(clk_en_i && level_ok) |=> strap_valid_o
	) else $error("capture did not raise valid");

	// High levels give ARP mode and their own code as strap_level_input bits.
	arp_decode_a: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		(clk_en_i && level_ok && strap_level_input_i[2]) |=>
			(!fixed_discoverable_mode_o
			&& strap_level_input_id_bits_o == $past(strap_level_input_i))
	) else $error("ARP level decoded wrongly");

	// Low levels give fixed mode with the base address plus the level.
	fixed_decode_a: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		(clk_en_i && level_ok && !strap_level_input_i[2]) |=>
			(fixed_discoverable_mode_o
			&& slave_addr_o == (bsd_pkg::FIXED_ADDR_BASE + 7'($past(strap_level_input_i))))
	) else $error("fixed level decoded wrongly");

	// ARP mode always carries a code from the upper half of the level range.
	mode_select_a: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		(strap_valid_o && !fixed_discoverable_mode_o) |-> strap_level_input_id_bits_o[2]
	) else $error("ARP mode without a high strap_level_input code");

	// Fixed mode leaves the strap_level_input bits and the identifier field at zero.
	fixed_unused_a: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		(strap_valid_o && fixed_discoverable_mode_o) |->
			(strap_level_input_id_bits_o == bsd_pkg::LOC_RESET && vendor_spec_id_o == '0)
	) else $error("fixed mode shows strap_level_input data");

	// ARP mode has no fixed address to offer, so the address output keeps its reset value.
	arp_unused_a: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		(strap_valid_o && !fixed_discoverable_mode_o) |-> slave_addr_o == bsd_pkg::ADDR_RESET
	) else $error("ARP mode shows a fixed address");

	// Strap_level_input bits sit just above the random field, with zeros above them.
	udid_place_a: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		(strap_valid_o && !fixed_discoverable_mode_o) |->
			(vendor_spec_id_o[18:16] == strap_level_input_id_bits_o && vendor_spec_id_o[31:19] == 13'h0000)
	) else $error("strap_level_input bits misplaced");

	// An assign-address command leaves the fixed address untouched.
	addr_hold_a: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		(strap_valid_o && fixed_discoverable_mode_o && assign_addr_i) |=> $stable(slave_addr_o)
	) else $error("fixed address replaced");

	// One start pulse of one enabled cycle; a low enable merely stretches it.
	start_pulse_a: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		(conv_start_o && clk_en_i) |=> (!conv_start_o && state_q == bsd_pkg::BSD_WAIT)
	) else $error("start pulse too long");

	// After the capture the converter is never started again.
	single_start_a: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		(state_q == bsd_pkg::BSD_DONE) |-> !conv_start_o
	) else $error("converter restarted after capture");

	// The start pulse only follows a full settling count, so the divider has settled.
	settle_end_a: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		$rose(conv_start_o) |->
			(state_q == bsd_pkg::BSD_WAIT && cnt_q == bsd_pkg::CNT_W'(bsd_pkg::SETTLE_CYC - 1))
	) else $error("converter started before settling");

	// A low clock enable holds every state register where it is.
	// The synchroniser is frozen as well, so a done edge is not lost while held.
	enable_freeze_a: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		!clk_en_i |=> ($stable(state_q) && $stable(cnt_q) && $stable(lfsr_q)
			&& $stable(strap_valid_o) && $stable(conv_start_o))
	) else $error("state moved while clock enable was low");
endmodule

// File: testbench/bsd_divider_model.sv
// Behavioural model of the resistor divider plus converter that feeds the strap decoder.
// Assumes the decoder pulses conv_start_i once per power-up and holds the code while done.
`timescale 1ns/1ps
module bsd_divider_model #(
	parameter int CONV_CYC = 5
) (
	input wire logic ref_clk_i, // Clock.
	input wire logic rst_i, // Power-on reset, active high.
	input wire logic conv_start_i, // Start pulse from the decoder.
	input wire logic [bsd_pkg::LEVEL_W-1:0] level_set_i, // Level the divider selects.
	output logic conv_done_o, // Conversion finished, held until reset.
	output logic [bsd_pkg::LEVEL_W-1:0] level_o // Level code, meaningful while done.
);
	int cnt_q;
	// Count the conversion time after a start; done then stays high until reset.
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_q <= 0;
			conv_done_o <= 1'b0;
		end else if (conv_start_i) begin
			cnt_q <= CONV_CYC;
		end else if (cnt_q > 1) begin
			cnt_q <= cnt_q - 1;
		end else if (cnt_q == 1) begin
			cnt_q <= 0;
			conv_done_o <= 1'b1;
		end
	end
	// Outside a finished conversion the code is inverted, so stale values never look right.
	assign level_o = conv_done_o ? level_set_i : ~level_set_i;
endmodule

// File: testbench/bus_strap_decoder_tb.sv
// Self-checking bench for the strap decoder: every divider level, then late changes.
// Assumes the divider model file and the design package are compiled first.
`timescale 1ns/1ps
module bus_strap_decoder_tb;
	logic ref_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic clk_en = 1'b1;
	logic assign_addr_i = 1'b0;
	logic [6:0] assign_addr_val_i = 7'h00;
	logic [2:0] level_set = 3'h0;
	logic [2:0] strap_level;
	logic conv_done;
	logic conv_start;
	logic strap_valid;
	logic fd_mode;
	logic [6:0] slave_addr;
	logic [2:0] loc;
	logic [31:0] vsid;
	int n_fail = 0;
	int tests_run = 0;
	// Free-running 50 MHz clock.
	always #10 ref_clk_i = ~ref_clk_i;
	bsd_divider_model model (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .conv_start_i(conv_start),
		.level_set_i(level_set), .conv_done_o(conv_done), .level_o(strap_level));
	bsd_strap_decoder dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .clk_en_i(clk_en),
		.strap_level_input_i(strap_level), .conv_done_i(conv_done),
		.assign_addr_i(assign_addr_i), .assign_addr_val_i(assign_addr_val_i),
		.conv_start_o(conv_start), .strap_valid_o(strap_valid),
		.fixed_discoverable_mode_o(fd_mode), .slave_addr_o(slave_addr),
		.strap_level_input_id_bits_o(loc), .vendor_spec_id_o(vsid));
	// Compare one value and count it.
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
			n_fail++;
		end
	endtask
	// Print the counts and the verdict, then stop.
	task automatic close_out;
		$display("Checks %0d, mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// Power up with one level, check start timing and decode, then disturb pin and bus.
	task automatic run_level(input logic [2:0] lvl);
		logic fd;
		logic [31:0] snap;
		logic [31:0] snap_id;
		int start_at;
		int n_start;
		fd = ~lvl[2];
		start_at = -1;
		n_start = 0;
		@(negedge ref_clk_i);
		rst_i = 1'b1;
		level_set = lvl;
		repeat (20) @(negedge ref_clk_i);
		rst_i = 1'b0;
		for (int i = 0; i < 400 && strap_valid !== 1'b1; i++) begin
			check("outputs_before_valid", 32'h0, {5'h0, fd_mode, slave_addr, loc, vsid[31:16]});
			if (conv_start === 1'b1) begin
				start_at = i;
				n_start++;
			end
			@(negedge ref_clk_i);
		end
		check("start_edge", 32'(bsd_pkg::SETTLE_CYC + 1), 32'(start_at));
		check("start_count", 32'h1, 32'(n_start));
		check("strap_valid", 32'h1, {31'h0, strap_valid});
		check("fixed_mode", {31'h0, fd}, {31'h0, fd_mode});
		check("slave_addr", fd ? {25'h0, 5'h14, lvl[1:0]} : 32'h0, {25'h0, slave_addr});
		check("strap_level_input_bits", fd ? 32'h0 : {29'h0, lvl}, {29'h0, loc});
		check("vsid_high", fd ? 32'h0 : {29'h0, lvl}, {16'h0, vsid[31:16]});
		if (fd) check("vsid_fixed", 32'h0, vsid);
		snap = {fd_mode, slave_addr, loc, 5'h0, vsid[31:16]};
		snap_id = vsid;
		level_set = ~lvl;
		assign_addr_i = 1'b1;
		assign_addr_val_i = 7'h2a;
		@(negedge ref_clk_i);
		assign_addr_i = 1'b0;
		repeat (20) @(negedge ref_clk_i);
		check("held_after_changes", snap, {fd_mode, slave_addr, loc, 5'h0, vsid[31:16]});
		check("vsid_held", snap_id, vsid);
	endtask
	// Power up with the clock enable low: nothing may move until it rises again.
	task automatic freeze_hold(input logic [2:0] lvl);
		int start_at;
		start_at = -1;
		@(negedge ref_clk_i);
		rst_i = 1'b1;
		clk_en = 1'b0;
		level_set = lvl;
		repeat (20) @(negedge ref_clk_i);
		rst_i = 1'b0;
		repeat (150) begin
			@(negedge ref_clk_i);
			check("frozen_outputs", 32'h0, {30'h0, conv_start, strap_valid});
		end
		clk_en = 1'b1;
		for (int i = 0; i < 400 && strap_valid !== 1'b1; i++) begin
			if (conv_start === 1'b1) begin
				start_at = i;
			end
			@(negedge ref_clk_i);
		end
		check("start_after_enable", 32'(bsd_pkg::SETTLE_CYC + 1), 32'(start_at));
		check("valid_after_enable", 32'h1, {31'h0, strap_valid});
		check("strap_level_input_after_enable", {29'h0, lvl}, {29'h0, loc});
	endtask
	// Run every level from lowest to highest, then the frozen power-up.
	initial begin
		for (int l = 0; l < 8; l++) begin
			run_level(l[2:0]);
		end
		freeze_hold(3'h6);
		close_out;
	end
	// Each level power-up needs about 150 cycles, the frozen one about 280, the run under 2000; a generous bound catches a hang.
	initial begin
		repeat (20000) @(posedge ref_clk_i);
		n_fail++;
		close_out;
	end
endmodule
